// ==== charge_cfg.svh ====
// Timing, address and field constants of the charge mode sequencer
`ifndef CHARGE_CFG_SVH
`define CHARGE_CFG_SVH

// ****************************************
// Clocking and timer chain
// ****************************************
`define CLK_HZ            40000000
`define OSC_DIV           40
`define TIMER_STAGES      34
`define SW1_BYPASS        19
`define SW2_BYPASS        11
`define SWA_BYPASS        5
`define SWB_BYPASS        11
`define SEL_CODE_BASE     4'h1

// ****************************************
// Times in their own units
// ****************************************
`define HOLDOFF_S         177
`define SAMPLE_PERIOD_MS  1380
`define GATE_LOW_US       1000

// ****************************************
// Register map
// ****************************************
`define ADDR_CTRL         8'h00
`define ADDR_STATUS       8'h04
`define CTRL_RESET        32'h00000002
`define CTRL_INHIBIT_BIT  0
`define CTRL_SLOPE_EN_BIT 1
`define SLOPES_TO_LATCH   2'h2

`endif

// ==== charge_pkg.sv ====
// Types shared by the charge mode sequencer
package charge_pkg;

    typedef enum logic [1:0] {
        MODE_TRICKLE,
        MODE_FAST,
        MODE_LATCHED
    } mode_t;

    typedef struct packed {
        mode_t       mode;
        logic        fast_trickle;
        logic        gate_out;
        logic        prev_window;
        logic        prev_supply;
        logic        rst_pulse;
        logic        otemp_latch;
        logic [1:0]  slope_cnt;
        logic        slope_seen;
        logic        prev_slope;
        logic [7:0]  prescale;
        logic        tick;
        logic        inhibit;
        logic        slope_en;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } seq_state_t;

endpackage

// ==== input_sync.sv ====
// Two-flop synchroniser for a bundle of comparator levels
`timescale 1ns/10ps
module input_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t st;
    sync_t next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;

endmodule

// ==== step_counter.sv ====
// Counter advancing by a selectable step, used for each divider chain
`timescale 1ns/10ps
module step_counter #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Control
    input  wire logic         clr,
    input  wire logic         en,
    input  wire logic [W-1:0] step,
    output logic      [W-1:0] count
);

    typedef struct packed {
        logic [W-1:0] value;
    } cnt_t;

    cnt_t st;
    cnt_t next_st;

    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.value = '0;
        end else if (en) begin
            next_st.value = st.value + step;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.value;

endmodule

// ==== charge_mode_sequencer.sv ====
// Charge mode sequencer: fast, trickle and latched trickle control with APB access
//
// Operation
// - Window entry selects fast and pulses reset
// - Two slope events after holdoff latch trickle
// - Latched trickle cleared only by reset pulse
// - Sense outside window forces plain trickle, except low sense in timer mode before expiry
// - Timer expiry in timer mode latches trickle
// - Fast entered only with supply, window, backup good
// - Under temperature holds trickle in temperature mode, no latching
// - Over temperature latch forces latched trickle
// - Undervoltage forces trickle, resets timer, latch
// - Backup timer is a 34-stage divider
// - Switch one skips 19 stages below window
// - Switch one delay scales the seven limits
// - Switch two skips 11 stages when selected below window
// - Switch two delay exercises skipped stages
// - Section A speeds sample gate 32 times
// - Section B speeds holdoff 2048 times
// - Sample gate pulses; low sense resets slopes
// - Select inputs pick limit or temperature mode
`include "charge_cfg.svh"
`timescale 1ns/10ps
module charge_mode_sequencer #(
    parameter int unsigned OSC_DIV       = `OSC_DIV,
    parameter int unsigned TIMER_STAGES  = `TIMER_STAGES,
    parameter int unsigned HOLDOFF_TICKS = `HOLDOFF_S * (`CLK_HZ / `OSC_DIV),
    parameter int unsigned SAMPLE_TICKS  = `SAMPLE_PERIOD_MS * (`CLK_HZ / `OSC_DIV / 1000),
    parameter int unsigned GATE_TICKS    = `GATE_LOW_US * (`CLK_HZ / `OSC_DIV / 1000000)
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Comparator levels from the analog front end
    input  wire logic        sense_below_low,
    input  wire logic        sense_above_high,
    input  wire logic        neg_slope_event,
    input  wire logic        select_a_upper_ref,
    input  wire logic        select_b_thermistor,
    input  wire logic        select_c_lower_ref,
    input  wire logic        select_a_test_bias,
    input  wire logic        temp_under,
    input  wire logic        temp_over,
    input  wire logic        supply_ok,
    input  wire logic        supply_uvlo,
    // Charger controls
    output logic             fast_trickle,
    output logic             sample_gate_out
);

    localparam int TW = TIMER_STAGES + 1;
    localparam int CW = 32;
    localparam logic [TW-1:0] STEP_ONE = TW'(1);
    localparam logic [TW-1:0] STEP_SW1 = TW'(1) << `SW1_BYPASS;
    localparam logic [TW-1:0] STEP_SW2 = TW'(1) << `SW2_BYPASS;
    localparam logic [CW-1:0] STEP_A   = CW'(1) << `SWA_BYPASS;
    localparam logic [CW-1:0] STEP_B   = CW'(1) << `SWB_BYPASS;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (OSC_DIV < 1 || OSC_DIV > 256) begin : g_chk_div
        $error("OSC_DIV must lie in 1..256");
    end
    if (TIMER_STAGES < `SW1_BYPASS + 1 || GATE_TICKS >= SAMPLE_TICKS) begin : g_chk_cnt
        $error("Timer stages or sample gate timing out of range");
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [10:0] pins_q;
    logic        low_q, high_q, slope_q, sel_a_q, sel_b_q, sel_c_q;
    logic        test_q, under_q, over_q, supply_q, uvlo_q;

    input_sync #(.W(11)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({sense_below_low, sense_above_high, neg_slope_event,
                    select_a_upper_ref, select_b_thermistor, select_c_lower_ref,
                    select_a_test_bias, temp_under, temp_over, supply_ok, supply_uvlo}),
        .q        (pins_q)
    );

    assign {low_q, high_q, slope_q, sel_a_q, sel_b_q, sel_c_q,
            test_q, under_q, over_q, supply_q, uvlo_q} = pins_q;

    charge_pkg::seq_state_t st;
    charge_pkg::seq_state_t next_st;

    // ****************************************
    // Decoded conditions
    // ****************************************
    logic          window_q;
    logic          timer_mode;
    logic [3:0]    sel_code;
    logic [TW-1:0] timer_limit;
    logic [TW-1:0] timer_cnt;
    logic [TW-1:0] timer_step;
    logic          timer_exp;
    logic [CW-1:0] hold_cnt;
    logic          hold_done;
    logic [CW-1:0] sample_cnt;
    logic          sample_wrap;
    logic          slope_rise;
    logic          backup_ok;
    logic          allow_fast;
    logic          test_hold;
    logic          latch_cond;

    assign window_q    = !low_q && !high_q;
    assign timer_mode  = sel_a_q || sel_b_q || sel_c_q;
    assign sel_code    = {1'b0, sel_c_q, sel_b_q, sel_a_q} + `SEL_CODE_BASE;
    assign timer_limit = TW'(sel_code) << (TIMER_STAGES - 3);
    assign timer_exp   = timer_mode && (timer_cnt >= timer_limit);
    assign hold_done   = hold_cnt >= CW'(HOLDOFF_TICKS);
    assign sample_wrap = sample_cnt >= CW'(SAMPLE_TICKS);
    assign slope_rise  = slope_q && !st.prev_slope;

    // Switch two wins over switch one when both are entered
    always_comb begin
        if (low_q && test_q) begin
            timer_step = STEP_SW2;
        end else if (low_q) begin
            timer_step = STEP_SW1;
        end else begin
            timer_step = STEP_ONE;
        end
    end

    assign backup_ok  = timer_mode ? !timer_exp : (!under_q && !st.otemp_latch);
    assign allow_fast = supply_q && !uvlo_q && window_q && backup_ok && !st.inhibit;
    // Low sense in timer mode keeps fast until expiry, so the tester sees the scaled delay
    assign test_hold  = low_q && timer_mode && !timer_exp && supply_q && !uvlo_q;
    assign latch_cond = (st.slope_cnt == `SLOPES_TO_LATCH) || timer_exp;

    // ****************************************
    // Divider chains
    // ****************************************
    step_counter #(.W(TW)) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (st.rst_pulse || uvlo_q),
        .en       (st.tick && st.mode == charge_pkg::MODE_FAST && !timer_exp),
        .step     (timer_step),
        .count    (timer_cnt)
    );

    step_counter #(.W(CW)) u_holdoff (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (st.rst_pulse),
        .en       (st.tick && !hold_done),
        .step     (test_q ? STEP_B : CW'(1)),
        .count    (hold_cnt)
    );

    step_counter #(.W(CW)) u_sample (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (sample_wrap),
        .en       (st.tick),
        .step     (test_q ? STEP_A : CW'(1)),
        .count    (sample_cnt)
    );

    // ****************************************
    // Next state
    // ****************************************
    logic apb_access;
    logic addr_ok;

    assign apb_access = psel && penable && !st.pready;
    assign addr_ok    = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS && !pwrite);

    always_comb begin
        next_st = st;

        // Oscillator tick
        if (st.prescale == 8'(OSC_DIV - 1)) begin
            next_st.prescale = 8'h00;
            next_st.tick     = 1'b1;
        end else begin
            next_st.prescale = st.prescale + 8'h01;
            next_st.tick     = 1'b0;
        end

        // Reset pulse on window entry or supply rise
        next_st.prev_window = window_q;
        next_st.prev_supply = supply_q;
        next_st.rst_pulse   = (window_q && !st.prev_window) || (supply_q && !st.prev_supply);

        // Overtemperature latch; lockout holds it clear, otherwise set beats clear
        if (uvlo_q) begin
            next_st.otemp_latch = 1'b0;
        end else if (!timer_mode && over_q) begin
            next_st.otemp_latch = 1'b1;
        end else if (st.rst_pulse) begin
            next_st.otemp_latch = 1'b0;
        end

        // Negative slope counting per sample period
        next_st.prev_slope = slope_q;
        if (low_q || st.rst_pulse || !st.slope_en) begin
            next_st.slope_cnt  = 2'h0;
            next_st.slope_seen = 1'b0;
        end else if (slope_rise && hold_done && window_q) begin
            if (st.slope_cnt != `SLOPES_TO_LATCH) begin
                next_st.slope_cnt = st.slope_cnt + 2'h1;
            end
            next_st.slope_seen = 1'b1;
        end else if (sample_wrap) begin
            if (!st.slope_seen) begin
                next_st.slope_cnt = 2'h0;
            end
            next_st.slope_seen = 1'b0;
        end

        // Mode selection
        unique case (st.mode)
            charge_pkg::MODE_LATCHED: begin
                if (st.rst_pulse) begin
                    next_st.mode = charge_pkg::MODE_TRICKLE;
                end
            end
            charge_pkg::MODE_FAST: begin
                if (st.otemp_latch || latch_cond) begin
                    next_st.mode = charge_pkg::MODE_LATCHED;
                end else if (!allow_fast && !test_hold) begin
                    next_st.mode = charge_pkg::MODE_TRICKLE;
                end
            end
            charge_pkg::MODE_TRICKLE: begin
                if (st.otemp_latch) begin
                    next_st.mode = charge_pkg::MODE_LATCHED;
                end else if (allow_fast) begin
                    next_st.mode = charge_pkg::MODE_FAST;
                end
            end
            default: begin
                next_st.mode = charge_pkg::MODE_TRICKLE;
            end
        endcase
        next_st.fast_trickle = (next_st.mode == charge_pkg::MODE_FAST);

        // Sample gate low at the start of each period
        next_st.gate_out = !(sample_cnt < CW'(GATE_TICKS));

        // APB slave, one wait state
        next_st.pready  = apb_access;
        next_st.pslverr = apb_access && !addr_ok;
        next_st.prdata  = 32'h00000000;
        if (apb_access && addr_ok) begin
            if (pwrite) begin
                next_st.inhibit  = pwdata[`CTRL_INHIBIT_BIT];
                next_st.slope_en = pwdata[`CTRL_SLOPE_EN_BIT];
            end else if (paddr == `ADDR_CTRL) begin
                next_st.prdata = {30'h0, st.slope_en, st.inhibit};
            end else begin
                next_st.prdata = {17'h0, st.gate_out, st.slope_cnt, uvlo_q, window_q,
                                  sel_c_q, sel_b_q, sel_a_q, timer_mode, hold_done,
                                  timer_exp, st.otemp_latch, st.fast_trickle, st.mode};
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.mode     <= charge_pkg::MODE_TRICKLE;
            st.gate_out <= 1'b1;
            st.inhibit  <= 1'b0;
            st.slope_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign fast_trickle    = st.fast_trickle;
    assign sample_gate_out = st.gate_out;
    assign prdata          = st.prdata;
    assign pready          = st.pready;
    assign pslverr         = st.pslverr;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_entry_pulse;
        window_q && !st.prev_window |=> st.rst_pulse ##1 timer_cnt == '0;
    endproperty
    a_entry_pulse: assert property (p_entry_pulse)
        else $error("Window entry did not reset the timer");

    property p_slope_latch;
        st.mode == charge_pkg::MODE_FAST && st.slope_cnt == `SLOPES_TO_LATCH
            |=> st.mode == charge_pkg::MODE_LATCHED;
    endproperty
    a_slope_latch: assert property (p_slope_latch)
        else $error("Two slope events did not latch trickle");

    property p_latch_hold;
        st.mode == charge_pkg::MODE_LATCHED && !st.rst_pulse
            |=> st.mode == charge_pkg::MODE_LATCHED;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latched trickle left without reset pulse");

    property p_high_trickle;
        high_q |=> !st.fast_trickle;
    endproperty
    a_high_trickle: assert property (p_high_trickle)
        else $error("Fast charge with sense above window");

    property p_timer_latch;
        st.mode == charge_pkg::MODE_FAST && timer_exp && !st.otemp_latch
            |=> st.mode == charge_pkg::MODE_LATCHED && !st.fast_trickle;
    endproperty
    a_timer_latch: assert property (p_timer_latch)
        else $error("Timer expiry did not latch trickle");

    property p_fast_cause;
        $rose(st.fast_trickle) |-> $past(allow_fast);
    endproperty
    a_fast_cause: assert property (p_fast_cause)
        else $error("Fast charge entered without all conditions");

    property p_under_temp;
        !timer_mode && under_q && !test_hold |=> !st.fast_trickle;
    endproperty
    a_under_temp: assert property (p_under_temp)
        else $error("Fast charge while under temperature");

    property p_otemp_sticky;
        st.otemp_latch && !st.rst_pulse && !uvlo_q |=> st.otemp_latch ##1 !st.fast_trickle;
    endproperty
    a_otemp_sticky: assert property (p_otemp_sticky)
        else $error("Overtemperature latch lost or fast charge kept");

    property p_uvlo;
        uvlo_q |=> !st.otemp_latch && timer_cnt == '0 && st.mode != charge_pkg::MODE_FAST;
    endproperty
    a_uvlo: assert property (p_uvlo)
        else $error("Lockout did not force trickle and resets");

    property p_sw1_step;
        low_q && !test_q && st.tick && st.mode == charge_pkg::MODE_FAST && !timer_exp
            && !st.rst_pulse && !uvlo_q |=> timer_cnt == $past(timer_cnt) + STEP_SW1;
    endproperty
    a_sw1_step: assert property (p_sw1_step)
        else $error("Switch one step wrong");

    property p_holdoff;
        !hold_done && st.slope_cnt == 2'h0 |=> st.slope_cnt == 2'h0;
    endproperty
    a_holdoff: assert property (p_holdoff)
        else $error("Slope counted during holdoff");

    c_fast:    cover property ($rose(st.fast_trickle));
    c_latched: cover property (st.mode == charge_pkg::MODE_LATCHED);
    c_gate:    cover property ($fell(st.gate_out));
    c_apb:     cover property (st.pready && !st.pslverr);

endmodule

// ==== charger_stage_model.sv ====
// Charger power stage model driven by the fast/trickle and sample-gate outputs
`timescale 1ns/10ps
module charger_stage_model (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Controls from the sequencer
    input  wire logic fast_trickle,
    input  wire logic sample_gate_out,
    // Observed behaviour
    output logic      charge_fast,
    output int        gate_count
);
    logic gate_prev;

    // Current interrupted while the gate is low
    assign charge_fast = fast_trickle & sample_gate_out;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_prev  <= 1'b1;
            gate_count <= 0;
        end else begin
            gate_prev <= sample_gate_out;
            if (gate_prev && !sample_gate_out) begin
                gate_count <= gate_count + 1;
            end
        end
    end
endmodule

// ==== test_charge_mode_sequencer.sv ====
// Self-checking bench for the charge mode sequencer
`timescale 1ns/10ps
module test_charge_mode_sequencer;
    typedef struct packed {
        logic        err;
        logic [31:0] mask;
        logic [31:0] val;
    } apb_note_t;
    localparam int DIV = 2;
    localparam int SAMPLE = 64;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, fast_trickle, sample_gate_out, charge_fast;
    logic        sense_below_low = 1'b1;
    logic        sense_above_high = 1'b0;
    logic        neg_slope_event = 1'b0;
    logic        select_a_upper_ref = 1'b1;
    logic        select_b_thermistor = 1'b1;
    logic        select_c_lower_ref = 1'b1;
    logic        select_a_test_bias = 1'b0;
    logic        temp_under = 1'b0;
    logic        temp_over = 1'b0;
    logic        supply_ok = 1'b1;
    logic        supply_uvlo = 1'b0;
    int          fail_count = 0;
    int          checks_done = 0;
    int          gate_count, delay, exp_delay, gate_start;
    logic [1:0]  code;
    apb_note_t   apb_q[$];
    apb_note_t   note;
    logic        ft_q[$];
    event        look;

    always #12.5 core_clk = ~core_clk;

    charge_mode_sequencer #(.OSC_DIV(DIV), .HOLDOFF_TICKS(50), .SAMPLE_TICKS(SAMPLE),
        .GATE_TICKS(4)) dut_u (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense_below_low(sense_below_low), .sense_above_high(sense_above_high),
        .neg_slope_event(neg_slope_event), .select_a_upper_ref(select_a_upper_ref),
        .select_b_thermistor(select_b_thermistor),
        .select_c_lower_ref(select_c_lower_ref), .select_a_test_bias(select_a_test_bias),
        .temp_under(temp_under), .temp_over(temp_over), .supply_ok(supply_ok),
        .supply_uvlo(supply_uvlo), .fast_trickle(fast_trickle),
        .sample_gate_out(sample_gate_out));

    charger_stage_model partner_u (.core_clk(core_clk), .rst(rst),
        .fast_trickle(fast_trickle), .sample_gate_out(sample_gate_out),
        .charge_fast(charge_fast), .gate_count(gate_count));

    // ****************************************
    // Comparison and reporting
    // ****************************************
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(look) check("fast_trickle", {31'h0, fast_trickle}, {31'h0, ft_q.pop_front()});

    always @(posedge core_clk) begin
        if (pready === 1'b1) begin
            note = apb_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note.err});
            check("prdata", prdata & note.mask, note.val);
        end
    end

    // ****************************************
    // Drivers
    // ****************************************
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task ft(input logic v);
        ft_q.push_back(v);
        cyc(8);
        #1 -> look;
        cyc(1);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input apb_note_t e);
        int n;
        apb_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        cyc(1);
        penable <= 1'b1;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check("pready", 32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(1);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {1'b0, m, v});
    endtask

    task reenter;
        sense_above_high <= 1'b1;
        cyc(8);
        sense_above_high <= 1'b0;
        ft(1'b1);
    endtask

    task slope_pulse;
        neg_slope_event <= 1'b1;
        cyc(4);
        neg_slope_event <= 1'b0;
    endtask

    initial begin
        cyc(100000);
        fail_count++;
        report_and_stop;
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        void'($urandom(73));
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        rd(8'h00, 32'hffffffff, 32'h2);
        apb(1'b1, 8'h08, 32'h1, {1'b1, 64'h0});
        apb(1'b1, 8'h04, 32'h3, {1'b1, 64'h0});
        apb(1'b0, 8'h0c, 32'h0, {1'b1, 64'h0});
        ft(1'b0);
        $display("test registers done");
        sense_below_low <= 1'b0;
        ft(1'b1);
        rd(8'h04, 32'h7, 32'h5);
        sense_above_high <= 1'b1;
        ft(1'b0);
        sense_above_high <= 1'b0;
        ft(1'b1);
        $display("test window done");
        cyc(120);
        slope_pulse();
        cyc(76);
        slope_pulse();
        ft(1'b0);
        rd(8'h04, 32'h3, 32'h2);
        supply_ok <= 1'b0;
        ft(1'b0);
        supply_ok <= 1'b1;
        ft(1'b1);
        $display("test slopes done");
        supply_uvlo <= 1'b1;
        ft(1'b0);
        rd(8'h04, 32'h800, 32'h800);
        supply_uvlo <= 1'b0;
        reenter();
        apb(1'b1, 8'h00, 32'h3, {1'b0, 64'h0});
        sense_above_high <= 1'b1;
        cyc(8);
        sense_above_high <= 1'b0;
        ft(1'b0);
        apb(1'b1, 8'h00, 32'h2, {1'b0, 64'h0});
        reenter();
        $display("test lockout done");
        {select_a_upper_ref, select_b_thermistor, select_c_lower_ref} <= 3'h0;
        temp_under <= 1'b1;
        ft(1'b0);
        temp_under <= 1'b0;
        ft(1'b1);
        temp_over <= 1'b1;
        ft(1'b0);
        temp_over <= 1'b0;
        ft(1'b0);
        rd(8'h04, 32'h4b, 32'h0a);
        reenter();
        $display("test temperature done");
        code = 2'($urandom_range(2, 1));
        select_a_upper_ref <= code[0];
        select_b_thermistor <= code[1];
        reenter();
        sense_below_low <= 1'b1;
        ft(1'b1);
        delay = 9;
        exp_delay = (int'(code) + 1) * 4096 * DIV;
        while (fast_trickle !== 1'b0 && delay < 40000) begin
            cyc(1);
            delay++;
        end
        check("timer_delay", 32'(delay >= exp_delay - 8 && delay <= exp_delay + 24), 32'h1);
        rd(8'h04, 32'h53, 32'h52);
        check("gate_pulses", 32'(gate_count > 0), 32'h1);
        $display("test timer done");
        select_a_test_bias <= 1'b1;
        sense_below_low <= 1'b0;
        ft(1'b1);
        rd(8'h04, 32'h20, 32'h20);
        gate_start = gate_count;
        cyc(256);
        exp_delay = 256 * 32 / (DIV * SAMPLE);
        delay = gate_count - gate_start;
        check("gate_speedup", 32'(delay >= exp_delay - 1 && delay <= exp_delay + 1), 32'h1);
        sense_below_low <= 1'b1;
        cyc((int'(code) + 1) * 4096 * DIV);
        ft(1'b1);
        $display("test switches done");
        report_and_stop;
    end
endmodule
